//--- pkg/nvmem_pkg.sv
package nvmem_pkg;

    // ========================================
    // address map, word index = cpu address
    localparam logic [15:0] REG_CTRL_IDX  = 16'h103b;
    localparam logic [15:0] REG_MAP_IDX   = 16'h103d;
    localparam logic [15:0] REG_OPT_IDX   = 16'h1039;
    localparam logic [15:0] REG_CFG_IDX   = 16'h103f;
    localparam logic [15:0] REG_STAT_IDX  = 16'h1038;
    localparam logic [9:0]  REG_BLOCK_TOP = 10'h040;
    localparam logic [15:0] EE_FIRST      = 16'hb600;
    localparam logic [15:0] EE_LAST       = 16'hb7ff;
    localparam logic [15:0] BOOT_FIRST    = 16'hbf40;
    localparam logic [15:0] ROM_FIRST     = 16'he000;
    localparam logic [3:0]  RAM_LOW_PAGE  = 4'h0;

    // ========================================
    // field positions
    localparam int CTRL_PUMP   = 0;
    localparam int CTRL_LATCH  = 1;
    localparam int CTRL_ERASE  = 2;
    localparam int CTRL_ROW    = 3;
    localparam int CTRL_BYTE   = 4;
    localparam int CTRL_UNUSED = 5;
    localparam int OPT_PUMPCLK = 6;
    localparam int CFG_EEPROM_ENABLE_CFG    = 0;
    localparam int CFG_ROM_ENABLE_CFG   = 1;
    localparam int ROW_SHIFT   = 4;

    // ========================================
    // reset values and misc
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MAP_RESET  = 8'h01;
    localparam logic [1:0] CFG_RESET  = 2'h3;
    localparam logic [7:0] ERASED     = 8'hff;
    localparam logic [6:0] MAP_WINDOW = 7'h40;
    localparam int EE_BYTES  = 512;
    localparam int RAM_BYTES = 256;

    // ========================================
    // timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int PROG_TIME_US = 10_000;
    localparam int PROG_CYCLES  = PROG_TIME_US * (CLK_HZ / 1_000_000);

    // ========================================
    // carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_in_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_out_s;

    typedef struct packed {
        apb_out_s    bus;
        logic [7:0]  ctrl;
        logic [7:0]  mapReg;
        logic        pumpSel;
        logic [1:0]  cfg;
        logic [6:0]  initCnt;
        logic        mapDone;
        logic        strapDone;
        logic        bootOn;
        logic        latValid;
        logic [8:0]  latAddr;
        logic [7:0]  latData;
        logic [16:0] hvCount;
        logic        hvEnable;
        logic        pumpClkSel;
        logic        romActive;
        logic        eeActive;
    } state_s;

endpackage : nvmem_pkg

//--- design/nvmem_ctrl.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module nvmem_ctrl
    import nvmem_pkg::*;
#(
    parameter int CELL_CYCLES = PROG_CYCLES
) (
    input  wire logic     sys_clk,
    input  wire logic     resetn,
    input  wire apb_in_s  apbIn,
    output var  apb_out_s apbOut,
    input  wire logic     singleChip,
    input  wire logic     bootstrapMode,
    output logic          hvEnable,
    output logic          pumpClkSel,
    output logic          romActive,
    output logic          bootRomActive,
    output logic          eeActive
);

    // ========================================
    // storage
    logic [7:0] eeMem  [EE_BYTES];
    logic [7:0] ramMem [RAM_BYTES];

    state_s st;
    state_s next_st;

    logic [15:0] cpuAddr;
    logic        addrOk;
    logic        regHit;
    logic        ramHit;
    logic        eeHit;
    logic        bootHit;
    logic        romHit;
    logic        firstCyc;
    logic        doneCyc;
    logic        doWrite;
    logic        hvOn;
    logic        cellDone;
    logic        opGo;
    logic        ramWe;
    logic [7:0]  wByte;
    logic [7:0]  readByte;

    // ========================================
    // decode
    always_comb begin
        cpuAddr  = apbIn.paddr[17:2];
        addrOk   = (apbIn.paddr[31:18] == '0) && (apbIn.paddr[1:0] == 2'b00);
        regHit   = addrOk && (cpuAddr[15:6] == REG_BLOCK_TOP);
        ramHit   = addrOk && (cpuAddr[15:8] == {st.mapReg[7:4], RAM_LOW_PAGE});
        eeHit    = addrOk && st.eeActive && (cpuAddr >= EE_FIRST)
                   && (cpuAddr <= EE_LAST);
        bootHit  = addrOk && st.bootOn && (cpuAddr >= BOOT_FIRST)
                   && (cpuAddr < ROM_FIRST);
        romHit   = addrOk && st.romActive && (cpuAddr >= ROM_FIRST);
        firstCyc = apbIn.psel && apbIn.penable && !st.bus.pready;
        doneCyc  = apbIn.psel && apbIn.penable && st.bus.pready;
        doWrite  = doneCyc && apbIn.pwrite;
        hvOn     = st.ctrl[CTRL_LATCH] && st.ctrl[CTRL_PUMP];
        cellDone = st.hvCount >= 17'(CELL_CYCLES);
        ramWe    = doWrite && ramHit && !regHit;
    end

    // ========================================
    // control byte as it would be written
    always_comb begin
        wByte = apbIn.pwdata[7:0];
        wByte[CTRL_UNUSED] = 1'b0;
        if (!st.ctrl[CTRL_LATCH] && wByte[CTRL_LATCH] && wByte[CTRL_PUMP]) begin
            wByte[CTRL_LATCH] = 1'b0;
            wByte[CTRL_PUMP]  = 1'b0;
        end
        opGo = doWrite && regHit && (cpuAddr == REG_CTRL_IDX) && hvOn
               && !wByte[CTRL_PUMP] && st.latValid && cellDone;
    end

    // ========================================
    // read mux
    always_comb begin
        readByte = 8'h00;
        if (regHit) begin
            case (cpuAddr)
                REG_CTRL_IDX: begin
                    readByte = st.ctrl;
                end
                REG_MAP_IDX: begin
                    readByte = st.mapReg;
                end
                REG_OPT_IDX: begin
                    readByte = 8'h00;
                    readByte[OPT_PUMPCLK] = st.pumpSel;
                end
                REG_CFG_IDX: begin
                    readByte = {6'h00, st.cfg};
                end
                REG_STAT_IDX: begin
                    readByte = {5'h00, st.latValid, hvOn, cellDone};
                end
                default: begin
                    readByte = 8'h00;
                end
            endcase
        end else if (ramHit) begin
            readByte = ramMem[cpuAddr[7:0]];
        end else if (eeHit) begin
            readByte = st.ctrl[CTRL_LATCH] ? 8'h00 : eeMem[cpuAddr[8:0]];
        end
    end

    // ========================================
    // next state
    always_comb begin
        next_st = st;
        // apb answer, one wait state
        if (firstCyc) begin
            next_st.bus.pready  = 1'b1;
            next_st.bus.prdata  = {24'h000000, readByte};
            next_st.bus.pslverr = !(regHit || ramHit || eeHit || bootHit || romHit);
        end else if (doneCyc) begin
            next_st.bus.pready  = 1'b0;
            next_st.bus.pslverr = 1'b0;
        end
        // mapping window
        if (st.initCnt != MAP_WINDOW) begin
            next_st.initCnt = st.initCnt + 7'h01;
        end
        // strap capture on first cycle after release
        if (!st.strapDone) begin
            next_st.strapDone = 1'b1;
            next_st.bootOn    = bootstrapMode;
        end
        // high-voltage interval timer
        if (hvOn) begin
            if (!cellDone) begin
                next_st.hvCount = st.hvCount + 17'h00001;
            end
        end else begin
            next_st.hvCount = '0;
        end
        // register writes
        if (doWrite && regHit) begin
            case (cpuAddr)
                REG_CTRL_IDX: begin
                    next_st.ctrl = wByte;
                    if (!wByte[CTRL_LATCH] || (hvOn && !wByte[CTRL_PUMP])) begin
                        next_st.latValid = 1'b0;
                    end
                end
                REG_MAP_IDX: begin
                    if (!st.mapDone && (st.initCnt != MAP_WINDOW)) begin
                        next_st.mapReg  = apbIn.pwdata[7:0];
                        next_st.mapDone = 1'b1;
                    end
                end
                REG_OPT_IDX: begin
                    next_st.pumpSel = apbIn.pwdata[OPT_PUMPCLK];
                end
                REG_CFG_IDX: begin
                    next_st.cfg = apbIn.pwdata[1:0];
                end
                default: begin
                    next_st.cfg = st.cfg;
                end
            endcase
        end else if (doWrite && !ramHit && eeHit && st.ctrl[CTRL_LATCH]
                     && !st.ctrl[CTRL_PUMP]) begin
            next_st.latValid = 1'b1;
            next_st.latAddr  = cpuAddr[8:0];
            next_st.latData  = apbIn.pwdata[7:0];
        end
        // registered outputs
        next_st.hvEnable   = next_st.ctrl[CTRL_LATCH] && next_st.ctrl[CTRL_PUMP];
        next_st.pumpClkSel = next_st.pumpSel;
        next_st.romActive  = next_st.cfg[CFG_ROM_ENABLE_CFG] || singleChip;
        next_st.eeActive   = next_st.cfg[CFG_EEPROM_ENABLE_CFG];
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st            <= '0;
            st.ctrl       <= CTRL_RESET;
            st.mapReg     <= MAP_RESET;
            st.cfg        <= CFG_RESET;
            st.romActive  <= 1'b1;
            st.eeActive   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // ram, no reset so contents survive a resetn pulse
    always_ff @(posedge sys_clk) begin
        if (ramWe) begin
            ramMem[cpuAddr[7:0]] <= apbIn.pwdata[7:0];
        end
    end

    // ========================================
    // eeprom cells
    genvar g;
    generate
        for (g = 0; g < EE_BYTES; g++) begin : g_cell
            logic hitByte;
            logic hitRow;
            always_comb begin
                hitByte = (st.latAddr == 9'(g));
                hitRow  = (st.latAddr[8:ROW_SHIFT] == 5'(g >> ROW_SHIFT));
            end
            always_ff @(posedge sys_clk) begin
                if (opGo) begin
                    if (st.ctrl[CTRL_ERASE]) begin
                        if (st.ctrl[CTRL_BYTE] ? hitByte
                            : (!st.ctrl[CTRL_ROW] || hitRow)) begin
                            eeMem[g] <= ERASED;
                        end
                    end else if (hitByte) begin
                        eeMem[g] <= eeMem[g] & st.latData;
                    end
                end
            end
        end
    endgenerate

    // ========================================
    // outputs
    always_comb begin
        apbOut        = st.bus;
        hvEnable      = st.hvEnable;
        pumpClkSel    = st.pumpClkSel;
        romActive     = st.romActive;
        bootRomActive = st.bootOn;
        eeActive      = st.eeActive;
    end

    // ========================================
    // checks
    logic [7:0] expByte;
    logic [8:0] expAddr;
    always_ff @(posedge sys_clk) begin
        expByte <= eeMem[st.latAddr] & st.latData;
        expAddr <= st.latAddr;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    both_bits_block_a: assert property (
        doWrite && regHit && (cpuAddr == REG_CTRL_IDX) && !st.ctrl[CTRL_LATCH]
        && (apbIn.pwdata[1:0] == 2'b11) |=> !st.ctrl[CTRL_LATCH] && !hvEnable)
        else $error("latch and pump set together");
    pump_write_ignored_a: assert property (
        doWrite && eeHit && !regHit && !ramHit && hvOn
        |=> $stable(st.latData) && $stable(st.latAddr))
        else $error("eeprom write taken while pump on");
    map_locked_a: assert property (
        doWrite && regHit && (cpuAddr == REG_MAP_IDX) && st.mapDone
        |=> $stable(st.mapReg))
        else $error("mapping register rewritten");
    unused_bit_zero_a: assert property (
        !st.ctrl[CTRL_UNUSED])
        else $error("unused control bit set");
    ee_read_isolated_a: assert property (
        firstCyc && !apbIn.pwrite && eeHit && !regHit && !ramHit
        && st.ctrl[CTRL_LATCH] |=> apbOut.pready && (apbOut.prdata == 32'h0))
        else $error("eeprom drove read bus during programming");
    single_chip_rom_a: assert property (
        singleChip |=> romActive)
        else $error("rom off in single-chip mode");
    program_and_a: assert property (
        opGo && !st.ctrl[CTRL_ERASE] |=> eeMem[expAddr] == expByte)
        else $error("program result is not and of old and new");
    byte_erase_a: assert property (
        opGo && st.ctrl[CTRL_ERASE] && st.ctrl[CTRL_BYTE] |=> eeMem[expAddr] == ERASED)
        else $error("byte erase did not leave ff");
    pump_off_a: assert property (
        doWrite && regHit && (cpuAddr == REG_CTRL_IDX) && !apbIn.pwdata[CTRL_PUMP]
        |=> !hvEnable)
        else $error("high voltage stayed on");
    boot_strap_a: assert property (
        $rose(st.strapDone) |-> bootRomActive == $past(bootstrapMode))
        else $error("boot rom enable wrong after reset");

endmodule : nvmem_ctrl

`default_nettype wire

//--- tb/apb_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// cpu side bus master, one transfer per call
module apb_cpu_model
    import nvmem_pkg::*;
(
    input  wire logic     sys_clk,
    output var  apb_in_s  apbIn,
    input  wire apb_out_s apbOut
);
    initial begin
        apbIn = '0;
    end

    // ========================================
    // setup, access until pready, then release
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic err);
        apbIn.psel    <= 1'b1;
        apbIn.penable <= 1'b0;
        apbIn.pwrite  <= wr;
        apbIn.paddr   <= {14'h0, addr, 2'h0};
        apbIn.pwdata  <= {24'h0, wdata};
        @(posedge sys_clk);
        apbIn.penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge sys_clk);
        end while (!apbOut.pready);
        rdata = apbOut.prdata[7:0];
        err   = apbOut.pslverr;
        apbIn.psel    <= 1'b0;
        apbIn.penable <= 1'b0;
        // released lines carry no stale value
        apbIn.paddr   <= ~apbIn.paddr;
        apbIn.pwdata  <= ~apbIn.pwdata;
        @(posedge sys_clk);
    endtask : xfer
endmodule : apb_cpu_model
`default_nettype wire

//--- tb/nvmem_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nvmem_ctrl_tb
    import nvmem_pkg::*;
;
    localparam int CELL  = 20;
    localparam int LIMIT = 20000;

    logic     sys_clk;
    logic     resetn;
    logic     singleChip;
    logic     bootstrapMode;
    logic     hvEnable;
    logic     pumpClkSel;
    logic     romActive;
    logic     bootRomActive;
    logic     eeActive;
    apb_in_s  apbIn;
    apb_out_s apbOut;
    int       err_total  = 0;
    int       num_checks = 0;
    int       cycles     = 0;

    nvmem_ctrl #(.CELL_CYCLES(CELL)) nvmem_ctrl_i (
        .sys_clk(sys_clk), .resetn(resetn), .apbIn(apbIn), .apbOut(apbOut),
        .singleChip(singleChip), .bootstrapMode(bootstrapMode), .hvEnable(hvEnable),
        .pumpClkSel(pumpClkSel), .romActive(romActive), .bootRomActive(bootRomActive),
        .eeActive(eeActive)
    );

    apb_cpu_model apb_cpu_model_i (.sys_clk(sys_clk), .apbIn(apbIn), .apbOut(apbOut));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // ========================================
    // report and checks
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            $display("mismatch run length expected %0d seen %0d", LIMIT, cycles);
            close_out();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ========================================
    // bus and pin tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] t;
        logic       e;
        apb_cpu_model_i.xfer(1'b1, a, d, t, e);
    endtask : wr

    task automatic rdc(input string what, input logic [15:0] a, input logic [7:0] exp,
                       input logic expErr);
        logic [7:0] t;
        logic       e;
        apb_cpu_model_i.xfer(1'b0, a, 8'h00, t, e);
        chk({what, " err"}, {7'h0, expErr}, {7'h0, e});
        if (!expErr) begin
            chk(what, exp, t);
        end
    endtask : rdc

    // order: hv, pump clock, rom, boot rom, eeprom
    task automatic pins(input string what, input logic [4:0] exp);
        @(negedge sys_clk);
        chk(what, {3'h0, exp}, {3'h0, hvEnable, pumpClkSel, romActive, bootRomActive, eeActive});
        @(posedge sys_clk);
    endtask : pins

    task automatic do_reset(input logic boot);
        resetn        <= 1'b0;
        bootstrapMode <= boot;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : do_reset

    // arm, latch a write, pump on, hold, pump off
    task automatic ee_op(input logic [7:0] arm, input logic [15:0] a, input logic [7:0] d,
                         input int hold);
        wr(REG_CTRL_IDX, arm);
        wr(a, d);
        wr(REG_CTRL_IDX, arm | 8'h01);
        pins("hv on", 5'b10111);
        wr(a, ~d);
        rdc("ee isolated", a, 8'h00, 1'b0);
        rdc("status", REG_STAT_IDX, 8'h06, 1'b0);
        repeat (hold) @(posedge sys_clk);
        wr(REG_CTRL_IDX, 8'h00);
    endtask : ee_op

    // ========================================
    // test sequence
    initial begin
        resetn        = 1'b0;
        singleChip    = 1'b0;
        bootstrapMode = 1'b1;
        do_reset(1'b1);
        pins("reset pins", 5'b00111);
        rdc("boot rom", BOOT_FIRST, 8'h00, 1'b0);
        rdc("ctrl reset", REG_CTRL_IDX, CTRL_RESET, 1'b0);
        rdc("map reset", REG_MAP_IDX, 8'h01, 1'b0);
        wr(REG_CTRL_IDX, 8'hff);
        rdc("ctrl layout", REG_CTRL_IDX, 8'hdc, 1'b0);
        pins("hv blocked", 5'b00111);
        wr(REG_CTRL_IDX, 8'h00);
        $display("test reset and layout done");
        ee_op(8'h06, 16'hb600, 8'h00, CELL + 2);
        rdc("bulk low", 16'hb600, ERASED, 1'b0);
        rdc("bulk high", 16'hb7ff, ERASED, 1'b0);
        ee_op(8'h02, 16'hb612, 8'h55, CELL + 2);
        rdc("program", 16'hb612, 8'h55, 1'b0);
        ee_op(8'h02, 16'hb612, 8'hf0, CELL + 2);
        rdc("program and", 16'hb612, 8'h50, 1'b0);
        ee_op(8'h02, 16'hb620, 8'h33, CELL + 2);
        ee_op(8'h02, 16'hb621, 8'h44, CELL + 2);
        ee_op(8'h0e, 16'hb61f, 8'h00, CELL + 2);
        rdc("row erased", 16'hb612, ERASED, 1'b0);
        rdc("row neighbour", 16'hb620, 8'h33, 1'b0);
        ee_op(8'h1e, 16'hb620, 8'h00, CELL + 2);
        rdc("byte erased", 16'hb620, ERASED, 1'b0);
        rdc("byte neighbour", 16'hb621, 8'h44, 1'b0);
        ee_op(8'h02, 16'hb630, 8'h00, 2);
        rdc("early off", 16'hb630, ERASED, 1'b0);
        wr(REG_CTRL_IDX, 8'h0c);
        wr(16'hb621, 8'h00);
        wr(REG_CTRL_IDX, 8'h0d);
        pins("no latch no hv", 5'b00111);
        repeat (CELL + 2) @(posedge sys_clk);
        wr(REG_CTRL_IDX, 8'h00);
        rdc("latch clear", 16'hb621, 8'h44, 1'b0);
        $display("test program and erase done");
        wr(REG_CFG_IDX, 8'h02);
        pins("ee off", 5'b00110);
        rdc("ee unmapped", 16'hb621, 8'h00, 1'b1);
        wr(REG_CFG_IDX, 8'h00);
        pins("rom off", 5'b00010);
        rdc("rom unmapped", ROM_FIRST, 8'h00, 1'b1);
        singleChip <= 1'b1;
        @(posedge sys_clk);
        pins("single chip rom", 5'b00110);
        singleChip <= 1'b0;
        wr(REG_CFG_IDX, CFG_RESET);
        wr(REG_OPT_IDX, 8'h40);
        pins("pump clock", 5'b01111);
        rdc("option", REG_OPT_IDX, 8'h40, 1'b0);
        rdc("unmapped", 16'h4000, 8'h00, 1'b1);
        $display("test enables done");
        do_reset(1'b0);
        pins("normal reset", 5'b00101);
        rdc("boot rom off", BOOT_FIRST, 8'h00, 1'b1);
        rdc("ctrl reset", REG_CTRL_IDX, CTRL_RESET, 1'b0);
        wr(REG_MAP_IDX, 8'h21);
        wr(16'h2010, 8'ha5);
        rdc("ram moved", 16'h2010, 8'ha5, 1'b0);
        rdc("ram old page", 16'h0010, 8'h00, 1'b1);
        wr(REG_MAP_IDX, 8'h31);
        rdc("map once", REG_MAP_IDX, 8'h21, 1'b0);
        do_reset(1'b0);
        repeat (70) @(posedge sys_clk);
        wr(REG_MAP_IDX, 8'h21);
        rdc("map late", REG_MAP_IDX, 8'h01, 1'b0);
        wr(16'h0020, 8'h3c);
        rdc("ram default", 16'h0020, 8'h3c, 1'b0);
        $display("test mapping done");
        close_out();
    end
endmodule : nvmem_ctrl_tb
`default_nettype wire
